/* File: src/arp_readout.sv */
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
// What the document asks of this block and its host
// R1 - A status request returns bits 7 and 5 zero, bit 6 new result, bit 4 continuity, bit 3 resolution, bits 2..1 type, bit 0 parity error.
// R2 - In pair modes each digit byte holds the even digit low and the odd digit high, the top byte carrying polarity, overrange and top digit.
// R3 - In addressed serial mode each digit byte has upper nibble 0011, digit 5 packing polarity, overrange and its two bits.
// R4 - After a single conversion the result registers stay unchanged until a new command.
// R5 - In continuous conversion every finished conversion overwrites the result registers.
// R6 - In continuous conversion the host reads status before and after the digits and drops a reading that was updated in between.
// R7 - The host avoids continuous conversion when the serial rate is too slow to move all bytes within one conversion.
// R8 - The serial data clock is sixteen times the baud rate, divided down from the converter clock.
// R9 - The clock to data-clock divider is 512, 128, 16 or 8 for the four baud selections.
// R10 - Serial baud scales with the clock while parallel transfers do not depend on it.
// R11 - The integration phase is a fixed count of clocks, 16.67ms at 2.4MHz.
// R12 - At a nonstandard clock the host sets its own divider to match the converter's data clock.
// R13 - Reading the status byte clears the new-result flag.
// R14 - The baud select pins give a total division of 8192, 2048, 256 or 128.
// R15 - A host byte with bit 0 low is a command and with bit 0 high a request.
// R16 - Serial bytes are one start bit, eight data bits lsb first and one stop bit.
module arp_readout
	import arp_pkg::*;
#(
	parameter int INTEG_LEN = arp_pkg::INTEG_CYCLES,
	parameter int INTEG_W = 16
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [arp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [arp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [arp_pkg::DATA_W-1:0] reg_rdata,
	output logic irq,
	input wire logic uart_rxd,
	output logic uart_txd,
	input wire logic baud_select_lo,
	input wire logic baud_select_hi,
	input wire logic par_req_valid,
	input wire logic [7:0] par_req_byte,
	output logic par_resp_valid,
	output logic [7:0] par_resp_byte,
	input wire logic conv_done,
	input wire arp_pkg::arp_result_t conv_result,
	output logic conv_start,
	output arp_pkg::arp_cfg_t conv_cfg,
	output logic integrating
);
	import arp_pkg::*;
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;
	logic [2:0] pin_s3_q;
	logic [2:0] pin_q;
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_s1_q <= 3'h1;
			pin_s2_q <= 3'h1;
			pin_s3_q <= 3'h1;
			pin_q <= 3'h1;
		end
		else
		begin
			pin_s1_q <= {baud_select_hi, baud_select_lo, uart_rxd};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			// accept a change only once two stages agree
			pin_q <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_q & (pin_s2_q ^ pin_s3_q));
		end
	end
	// ------------------------------------------------------------
	// data clock
	// ------------------------------------------------------------
	function automatic logic [9:0] data_clk_div(input logic [1:0] sel);
		case (sel)
			2'b00: data_clk_div = DIV_300;
			2'b01: data_clk_div = DIV_1200;
			2'b10: data_clk_div = DIV_9600;
			default: data_clk_div = DIV_19200;
		endcase
	endfunction : data_clk_div
	logic [9:0] div_cnt_q;
	logic tick_q;
	logic [9:0] div_now;
	assign div_now = data_clk_div(pin_q[2:1]); // [R9]
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			div_cnt_q <= 10'h000;
			tick_q <= 1'b0;
		end
		else if (div_cnt_q >= div_now - 10'h001)
		begin
			// counting core clocks keeps baud proportional to the clock
			div_cnt_q <= 10'h000;
			tick_q <= 1'b1; // [R8] [R10]
		end
		else
		begin
			div_cnt_q <= div_cnt_q + 10'h001;
			tick_q <= 1'b0;
		end
	end
	// ------------------------------------------------------------
	// serial engines, each bit is 16 data clocks
	// ------------------------------------------------------------
	logic rx_valid;
	logic [7:0] rx_byte;
	logic rx_ferr;
	logic tx_busy;
	logic tx_start_q;
	logic [7:0] tx_byte_q;
	arp_rx u_rx
	(
		.core_clk(core_clk),
		.arst_n(arst_n),
		.tick(tick_q),
		.rxd(pin_q[0]),
		.byte_valid(rx_valid),
		.byte_data(rx_byte),
		.frame_err(rx_ferr)
	); // [R14]
	arp_tx u_tx
	(
		.core_clk(core_clk),
		.arst_n(arst_n),
		.tick(tick_q),
		.start(tx_start_q),
		.data(tx_byte_q),
		.busy(tx_busy),
		.txd(uart_txd)
	);
	// ------------------------------------------------------------
	// host byte source
	// ------------------------------------------------------------
	logic [7:0] ctrl_q;
	arp_mode_t mode;
	logic host_valid;
	logic [7:0] host_byte;
	logic host_err;
	assign mode = arp_mode_t'(ctrl_q[1:0]);
	always_comb
	begin
		// parallel transfers use no baud timing at all
		if (mode == MODE_PAR)
		begin
			host_valid = par_req_valid; // [R10]
			host_byte = par_req_byte;
			host_err = 1'b0;
		end
		else
		begin
			host_valid = rx_valid;
			host_byte = rx_byte;
			host_err = rx_ferr;
		end
	end
	logic is_cmd;
	logic is_req;
	assign is_cmd = host_valid && !host_byte[BYTE_KIND_BIT]; // [R15]
	assign is_req = host_valid && host_byte[BYTE_KIND_BIT]; // [R15]
	// ------------------------------------------------------------
	// conversion control and results
	// ------------------------------------------------------------
	logic active_q;
	logic new_q;
	logic perr_q;
	arp_result_t result_q;
	logic [INTEG_W-1:0] integ_cnt_q;
	logic accept_done;
	assign accept_done = conv_done && active_q;
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			conv_cfg <= CFG_RST;
			conv_start <= 1'b0;
			active_q <= 1'b0;
		end
		else
		begin
			conv_start <= is_cmd;
			if (is_cmd)
			begin
				conv_cfg <= arp_cfg_t'(host_byte[4:1]);
				active_q <= 1'b1;
			end
			else if (accept_done && !conv_cfg.continuous)
				active_q <= 1'b0; // [R4]
		end
	end
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			result_q <= '0;
		else if (accept_done)
			result_q <= conv_result; // [R4] [R5]
	end
	// ------------------------------------------------------------
	// integration phase timer
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			integ_cnt_q <= '0;
			integrating <= 1'b0;
		end
		else if (is_cmd || (accept_done && conv_cfg.continuous))
		begin
			integ_cnt_q <= INTEG_W'(INTEG_LEN - 1); // [R11]
			integrating <= 1'b1;
		end
		else if (integ_cnt_q != '0)
			integ_cnt_q <= integ_cnt_q - 1'b1;
		else
			integrating <= 1'b0;
	end
	// ------------------------------------------------------------
	// response bytes
	// ------------------------------------------------------------
	function automatic logic [7:0] status_byte(input logic nw, input arp_cfg_t c,
		input logic pe);
		status_byte = {1'b0, nw, 1'b0, c.continuous, c.high_res, c.conv_type, pe}; // [R1]
	endfunction : status_byte
	function automatic logic [7:0] pair_byte(input arp_result_t r, input logic [1:0] p);
		case (p)
			2'h0: pair_byte = {r.digit[1], r.digit[0]}; // [R2]
			2'h1: pair_byte = {r.digit[3], r.digit[2]};
			default: pair_byte = {r.polarity, r.overrange, r.top_digit, r.digit[4]}; // [R2]
		endcase
	endfunction : pair_byte
	function automatic logic [7:0] single_byte(input arp_result_t r, input logic [2:0] d);
		if (d == 3'h5)
			single_byte = {DIGIT_TAG, r.polarity, r.overrange, r.top_digit}; // [R3]
		else if (d > 3'h5)
			// reserved codes must not index past digit 4
			single_byte = {DIGIT_TAG, 4'h0};
		else
			single_byte = {DIGIT_TAG, r.digit[d]}; // [R3]
	endfunction : single_byte
	logic status_req;
	logic [7:0] resp;
	always_comb
	begin
		status_req = 1'b0;
		if (mode == MODE_ADDR)
		begin
			status_req = (host_byte[3:1] == REQ_STATUS_ADDR);
			resp = single_byte(result_q, host_byte[3:1]);
		end
		else
		begin
			status_req = (host_byte[3:2] == REQ_STATUS_PAIR);
			resp = pair_byte(result_q, host_byte[3:2]);
		end
		if (status_req)
			resp = status_byte(new_q, conv_cfg, perr_q);
	end
	// a request that lands while a reply is still shifting out is dropped
	logic req_taken;
	assign req_taken = is_req && (mode == MODE_PAR || !tx_busy);
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			new_q <= 1'b0;
			perr_q <= 1'b0;
		end
		else
		begin
			if (host_valid)
				perr_q <= host_err;
			// set beats clear in the same cycle
			if (accept_done)
				new_q <= 1'b1;
			else if (req_taken && status_req)
				new_q <= 1'b0; // [R13] [R6]
		end
	end
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_start_q <= 1'b0;
			tx_byte_q <= 8'h00;
			par_resp_valid <= 1'b0;
			par_resp_byte <= 8'h00;
		end
		else
		begin
			tx_start_q <= req_taken && mode != MODE_PAR;
			par_resp_valid <= req_taken && mode == MODE_PAR;
			if (req_taken && mode != MODE_PAR)
				tx_byte_q <= resp;
			if (req_taken && mode == MODE_PAR)
				par_resp_byte <= resp;
		end
	end
	// ------------------------------------------------------------
	// register port and interrupt
	// ------------------------------------------------------------
	logic [3:0] irq_stat_q;
	logic [3:0] irq_mask_q;
	logic [3:0] irq_ev;
	logic [7:0] last_req_q;
	assign irq_ev = {is_req && host_err, is_cmd, req_taken, accept_done};
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_q <= CTRL_RST;
			irq_mask_q <= IRQ_MASK_RST;
			irq_stat_q <= 4'h0;
			last_req_q <= 8'h00;
		end
		else
		begin
			if (reg_wr && reg_addr == ADDR_CTRL)
				ctrl_q <= {6'h00, reg_wdata[1:0]};
			if (reg_wr && reg_addr == ADDR_IRQ_MASK)
				irq_mask_q <= reg_wdata[3:0];
			if (host_valid)
				last_req_q <= host_byte;
			if (reg_wr && reg_addr == ADDR_IRQ_STAT)
				irq_stat_q <= (irq_stat_q & ~reg_wdata[3:0]) | irq_ev;
			else
				irq_stat_q <= irq_stat_q | irq_ev;
		end
	end
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_rdata <= 8'h00;
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(irq_stat_q & irq_mask_q);
			reg_rdata <= 8'h00;
			if (reg_rd)
			begin
				// software view of status does not clear the new flag
				case (reg_addr)
					ADDR_CTRL: reg_rdata <= ctrl_q;
					ADDR_STATUS: reg_rdata <= status_byte(new_q, conv_cfg, perr_q);
					ADDR_IRQ_STAT: reg_rdata <= {4'h0, irq_stat_q};
					ADDR_IRQ_MASK: reg_rdata <= {4'h0, irq_mask_q};
					ADDR_BAUD: reg_rdata <= {5'h00, active_q, pin_q[2:1]};
					ADDR_LAST_REQ: reg_rdata <= last_req_q;
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule : arp_readout

/* File: src/arp_pkg.sv */
package arp_pkg;
	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
	localparam logic [3:0] ADDR_BAUD = 4'h4;
	localparam logic [3:0] ADDR_LAST_REQ = 4'h5;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;
	// irq bit positions
	localparam int IRQ_DONE = 0;
	localparam int IRQ_REQ = 1;
	localparam int IRQ_CMD = 2;
	localparam int IRQ_FERR = 3;
	// ------------------------------------------------------------
	// host byte and status byte layout
	// ------------------------------------------------------------
	localparam int BYTE_KIND_BIT = 0;
	localparam int ST_NEW_BIT = 6;
	localparam int ST_CONT_BIT = 4;
	localparam int ST_RES_BIT = 3;
	localparam int ST_PERR_BIT = 0;
	localparam logic [1:0] REQ_STATUS_PAIR = 2'h3;
	localparam logic [2:0] REQ_STATUS_ADDR = 3'h6;
	localparam logic [3:0] DIGIT_TAG = 4'h3;
	localparam logic [1:0] TYPE_COMP = 2'h3;
	localparam logic [1:0] TYPE_UNCOMP = 2'h2;
	localparam logic [1:0] TYPE_ERR_ONLY = 2'h1;
	// ------------------------------------------------------------
	// serial timing
	// ------------------------------------------------------------
	localparam logic [9:0] DIV_300 = 10'd512;
	localparam logic [9:0] DIV_1200 = 10'd128;
	localparam logic [9:0] DIV_9600 = 10'd16;
	localparam logic [9:0] DIV_19200 = 10'd8;
	localparam logic [3:0] TICKS_LAST = 4'd15;
	localparam logic [3:0] MID_SAMPLE = 4'd7;
	// integration phase: fixed count of converter clocks
	localparam longint INTEG_TIME_NS = 16670000;
	localparam longint INTEG_REF_HZ = 2400000;
	localparam int INTEG_CYCLES = int'(INTEG_TIME_NS * INTEG_REF_HZ / 1000000000);
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		MODE_PAR = 2'b00,
		MODE_SER = 2'b01,
		MODE_ADDR = 2'b10
	} arp_mode_t;
	typedef struct packed
	{
		logic continuous;
		logic high_res;
		logic [1:0] conv_type;
	} arp_cfg_t;
	localparam arp_cfg_t CFG_RST = '{1'b0, 1'b1, TYPE_COMP};
	typedef struct packed
	{
		logic polarity;
		logic overrange;
		logic [1:0] top_digit;
		logic [4:0][3:0] digit;
	} arp_result_t;
endpackage : arp_pkg

/* File: src/arp_rx.sv */
`timescale 1ns/100ps
module arp_rx
	import arp_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic tick,
	input wire logic rxd,
	output logic byte_valid,
	output logic [7:0] byte_data,
	output logic frame_err
);
	typedef enum logic [1:0]
	{
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} arp_rx_state_t;
	arp_rx_state_t state_q;
	logic [3:0] tcnt_q;
	logic [2:0] bcnt_q;
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= RX_IDLE;
			tcnt_q <= 4'h0;
			bcnt_q <= 3'h0;
			byte_data <= 8'h00;
			byte_valid <= 1'b0;
			frame_err <= 1'b0;
		end
		else
		begin
			byte_valid <= 1'b0;
			if (tick)
			begin
				tcnt_q <= tcnt_q + 4'h1;
				case (state_q)
					RX_IDLE:
					begin
						tcnt_q <= 4'h0;
						if (!rxd)
							state_q <= RX_START;
					end
					RX_START:
						if (tcnt_q == MID_SAMPLE)
						begin
							// re-check mid start bit to reject glitches
							tcnt_q <= 4'h0;
							bcnt_q <= 3'h0;
							state_q <= rxd ? RX_IDLE : RX_DATA;
						end
					RX_DATA:
						if (tcnt_q == TICKS_LAST)
						begin
							byte_data <= {rxd, byte_data[7:1]}; // [R16]
							bcnt_q <= bcnt_q + 3'h1;
							if (bcnt_q == 3'h7)
								state_q <= RX_STOP;
						end
					RX_STOP:
						if (tcnt_q == TICKS_LAST)
						begin
							byte_valid <= 1'b1;
							frame_err <= !rxd;
							state_q <= RX_IDLE;
						end
					default:
						state_q <= RX_IDLE;
				endcase
			end
		end
	end
endmodule : arp_rx

/* File: src/arp_tx.sv */
`timescale 1ns/100ps
module arp_tx
	import arp_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic tick,
	input wire logic start,
	input wire logic [7:0] data,
	output logic busy,
	output logic txd
);
	typedef enum logic [1:0]
	{
		TX_IDLE = 2'b00,
		TX_START = 2'b01,
		TX_DATA = 2'b10,
		TX_STOP = 2'b11
	} arp_tx_state_t;
	arp_tx_state_t state_q;
	logic [3:0] tcnt_q;
	logic [2:0] bcnt_q;
	logic [7:0] sh_q;
	assign busy = (state_q != TX_IDLE);
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= TX_IDLE;
			tcnt_q <= 4'h0;
			bcnt_q <= 3'h0;
			sh_q <= 8'h00;
			txd <= 1'b1;
		end
		else if (state_q == TX_IDLE)
		begin
			if (start)
			begin
				sh_q <= data;
				tcnt_q <= 4'h0;
				state_q <= TX_START;
			end
		end
		else if (tick)
		begin
			tcnt_q <= tcnt_q + 4'h1;
			case (state_q)
				TX_START:
					txd <= 1'b0;
				TX_DATA:
					txd <= sh_q[bcnt_q]; // [R16]
				TX_STOP:
					txd <= 1'b1;
				default:
					txd <= 1'b1;
			endcase
			if (tcnt_q == TICKS_LAST)
			begin
				case (state_q)
					TX_START:
					begin
						bcnt_q <= 3'h0;
						state_q <= TX_DATA;
					end
					TX_DATA:
					begin
						bcnt_q <= bcnt_q + 3'h1;
						if (bcnt_q == 3'h7)
							state_q <= TX_STOP;
					end
					default:
						state_q <= TX_IDLE;
				endcase
			end
		end
	end
endmodule : arp_tx

/* File: sim/arp_readout_monitor.sv */
`timescale 1ns/100ps
// --------
// readout checker
// --------
module arp_readout_monitor
	import arp_pkg::*;
#(
	parameter int INTEG_LEN = 20
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [arp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [arp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic uart_txd,
	input wire logic baud_select_lo,
	input wire logic baud_select_hi,
	input wire logic par_req_valid,
	input wire logic [7:0] par_req_byte,
	input wire logic par_resp_valid,
	input wire logic [7:0] par_resp_byte,
	input wire logic conv_done,
	input wire logic conv_start,
	input wire arp_pkg::arp_cfg_t conv_cfg,
	input wire logic integrating
);
	logic [1:0] mode_q;
	logic [15:0] integ_q;
	logic [16:0] low_q;
	logic [16:0] bit_len;
	logic cmd;
	logic req;
	import arp_pkg::*;
	logic stat_req;
	logic [3:0] req_cfg;
	// mode is only seen through control writes, so track it here
	assign req_cfg = par_req_byte[4:1];
	assign cmd = par_req_valid && mode_q == 2'h0 && !par_req_byte[BYTE_KIND_BIT];
	assign req = par_req_valid && mode_q == 2'h0 && par_req_byte[BYTE_KIND_BIT];
	assign stat_req = req && par_req_byte[3:2] == REQ_STATUS_PAIR;
	assign bit_len = baud_select_hi ? (baud_select_lo ? 17'd128 : 17'd256)
		: (baud_select_lo ? 17'd2048 : 17'd8192);
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode_q <= 2'h0;
			integ_q <= 16'h0;
			low_q <= 17'h0;
		end
		else
		begin
			if (reg_wr && reg_addr == ADDR_CTRL)
				mode_q <= reg_wdata[1:0];
			integ_q <= integrating ? integ_q + 16'h1 : 16'h0;
			low_q <= uart_txd ? 17'h0 : low_q + 17'h1;
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	property p_status_fmt;
		stat_req |=> par_resp_valid && !par_resp_byte[7] && !par_resp_byte[5] && par_resp_byte[4:1] == conv_cfg;
	endproperty
	a_status_fmt: assert property (p_status_fmt) else $error("status byte wrong");
	property p_cmd_start;
		cmd |=> conv_start && !par_resp_valid;
	endproperty
	a_cmd_start: assert property (p_cmd_start) else $error("command did not start");
	property p_req_answer;
		req |=> par_resp_valid && !conv_start;
	endproperty
	a_req_answer: assert property (p_req_answer) else $error("request not answered");
	property p_cfg;
		cmd |=> conv_cfg == $past(req_cfg);
	endproperty
	a_cfg: assert property (p_cfg) else $error("config not taken from command");
	// a restart while high lengthens the run; the bench waits for idle first
	property p_integ_len;
		$fell(integrating) |-> integ_q == INTEG_LEN;
	endproperty
	a_integ_len: assert property (p_integ_len) else $error("integration length wrong");
	property p_integ_start;
		conv_start |-> ##[0:1] integrating;
	endproperty
	a_integ_start: assert property (p_integ_start) else $error("integration not started");
	property p_new_clear;
		(stat_req && !conv_done) ##1 (stat_req && !conv_done) |=> !par_resp_byte[ST_NEW_BIT];
	endproperty
	a_new_clear: assert property (p_new_clear) else $error("new flag not cleared");
	property p_tx_bits;
		$rose(uart_txd) |-> low_q % bit_len == 17'h0;
	endproperty
	a_tx_bits: assert property (p_tx_bits) else $error("tx bit length wrong");
	c_new: cover property (stat_req ##1 par_resp_byte[ST_NEW_BIT]);
	c_cont: cover property (conv_cfg.continuous && conv_done);
	c_tx: cover property ($rose(uart_txd));
endmodule : arp_readout_monitor

bind arp_readout arp_readout_monitor #(.INTEG_LEN(INTEG_LEN)) u_arp_readout_monitor
(
	.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .uart_txd, .baud_select_lo,
	.baud_select_hi, .par_req_valid, .par_req_byte, .par_resp_valid, .par_resp_byte,
	.conv_done, .conv_start, .conv_cfg, .integrating
);

/* File: sim/arp_host_model.sv */
`timescale 1ns/100ps
// --------
// host uart, 8n1 lsb first
// --------
module arp_host_model
(
	input wire logic core_clk,
	input wire logic line_in,
	output logic line_out
);
	initial line_out = 1'b1;
	// caller gives the bit length matching the device divider
	// a low stop bit forces a framing error; the line idles high afterwards
	task automatic send_byte(input logic [7:0] b, input int bit_len, input logic stop_bit);
		logic [9:0] frame;
		frame = {stop_bit, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge core_clk);
			line_out <= frame[i];
			repeat (bit_len - 1) @(posedge core_clk);
		end
		@(posedge core_clk);
		line_out <= 1'b1;
	endtask : send_byte
	// samples mid-bit; no start or no stop bit leaves ok low
	task automatic recv_byte(input int bit_len, output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		while (line_in !== 1'b0 && n < 40 * bit_len)
		begin
			@(posedge core_clk);
			n++;
		end
		repeat (bit_len / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (bit_len) @(posedge core_clk);
			b[i] = line_in;
		end
		repeat (bit_len) @(posedge core_clk);
		ok = line_in === 1'b1 && n < 40 * bit_len;
	endtask : recv_byte
endmodule : arp_host_model

/* File: sim/testbench.sv */
`timescale 1ns/100ps
// --------
// readout bench
// --------
module testbench;
	import arp_pkg::*;
	localparam arp_result_t RES_A = {1'b1, 1'b0, 2'h1, 20'h98765};
	localparam arp_result_t RES_B = {1'b0, 1'b1, 2'h2, 20'h43210};
	// request, answer
	localparam logic [15:0] PAR_ROWS [5] = '{16'h0d4e, 16'h0d0e, 16'h0165, 16'h0587, 16'h0999};
	// mode, baud select (bit 3: low stop bit), request, answer
	// fast rates only and no conversions while serial, slow links would miss results
	localparam logic [23:0] SER_ROWS [6] = '{24'h230b39, 24'h220336, 24'h130999, 24'h120587,
		24'h1a0d1e, 24'h120d1f};
	logic core_clk, arst_n, reg_wr, reg_rd, irq, uart_rxd, uart_txd, baud_select_lo;
	logic baud_select_hi, par_req_valid, par_resp_valid, conv_done, conv_start, integrating;
	logic st, ok;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, par_req_byte, par_resp_byte, r;
	arp_cfg_t conv_cfg;
	arp_result_t conv_result;
	int bad_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int bl;
	arp_readout #(.INTEG_LEN(20)) u_arp_readout
	(
		.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
		.uart_rxd, .uart_txd, .baud_select_lo, .baud_select_hi, .par_req_valid, .par_req_byte,
		.par_resp_valid, .par_resp_byte, .conv_done, .conv_result, .conv_start, .conv_cfg,
		.integrating
	);
	arp_host_model u_arp_host_model
	(
		.core_clk, .line_in(uart_txd), .line_out(uart_rxd)
	);
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			bad_count++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic strobe(input logic wr, input logic rd, input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= wr;
		reg_rd <= rd;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 r = reg_rdata;
	endtask : strobe
	task automatic par_req(input logic [7:0] b);
		@(posedge core_clk);
		par_req_valid <= 1'b1;
		par_req_byte <= b;
		@(posedge core_clk);
		par_req_valid <= 1'b0;
		#1 r = par_resp_byte;
		st = conv_start;
	endtask : par_req
	// waits out integration so a restart never overlaps it
	task automatic conv(input arp_result_t res);
		int n;
		n = 0;
		repeat (2) @(posedge core_clk);
		while (integrating !== 1'b0 && n < 200)
		begin
			@(posedge core_clk);
			n++;
		end
		conv_done <= 1'b1;
		conv_result <= res;
		@(posedge core_clk);
		conv_done <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask : conv
	initial
	begin
		{arst_n, reg_wr, reg_rd, par_req_valid, conv_done, reg_addr, reg_wdata} = '0;
		{par_req_byte, conv_result, baud_select_lo, baud_select_hi} = '0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		strobe(1'b0, 1'b1, ADDR_CTRL, 8'h00);
		check(r, CTRL_RST);
		strobe(1'b0, 1'b1, ADDR_IRQ_MASK, 8'h00);
		check(r, {4'h0, IRQ_MASK_RST});
		strobe(1'b0, 1'b1, 4'hf, 8'h00);
		check(r, 8'h00);
		check({4'h0, conv_cfg}, {4'h0, CFG_RST});
		check({7'h0, uart_txd}, 8'h01);
		strobe(1'b1, 1'b0, ADDR_IRQ_MASK, 8'h01);
		par_req(8'h0e);
		check({7'h0, st}, 8'h01);
		conv(RES_A);
		check({7'h0, irq}, 8'h01);
		strobe(1'b1, 1'b0, ADDR_IRQ_STAT, 8'h0f);
		@(posedge core_clk);
		#1 check({7'h0, irq}, 8'h00);
		foreach (PAR_ROWS[i])
		begin
			par_req(PAR_ROWS[i][15:8]);
			check(r, PAR_ROWS[i][7:0]);
		end
		conv(RES_B);
		par_req(8'h01);
		check(r, 8'h65);
		strobe(1'b1, 1'b0, ADDR_IRQ_MASK, 8'h00);
		par_req(8'h1e);
		conv(RES_B);
		check({7'h0, irq}, 8'h00);
		par_req(8'h0d);
		check(r, 8'h5e);
		par_req(8'h01);
		check(r, 8'h10);
		conv(RES_A);
		par_req(8'h01);
		check(r, 8'h65);
		repeat (2)
		begin
			strobe(1'b0, 1'b1, ADDR_STATUS, 8'h00);
			check(r, 8'h5e);
		end
		par_req(8'h0d);
		check(r, 8'h5e);
		@(posedge core_clk);
		par_req_valid <= 1'b1;
		par_req_byte <= 8'h0d;
		repeat (2) @(posedge core_clk);
		par_req_valid <= 1'b0;
		#1 check(par_resp_byte, 8'h1e);
		strobe(1'b0, 1'b1, ADDR_IRQ_STAT, 8'h00);
		check(r, 8'h07);
		strobe(1'b1, 1'b0, ADDR_IRQ_STAT, 8'h0f);
		strobe(1'b0, 1'b1, ADDR_IRQ_STAT, 8'h00);
		check(r, 8'h00);
		foreach (SER_ROWS[i])
		begin
			strobe(1'b1, 1'b0, ADDR_CTRL, {4'h0, SER_ROWS[i][23:20]});
			@(posedge core_clk);
			{baud_select_hi, baud_select_lo} <= SER_ROWS[i][17:16];
			bl = SER_ROWS[i][16] ? 128 : 256;
			repeat (4) @(posedge core_clk);
			fork
				u_arp_host_model.send_byte(SER_ROWS[i][15:8], bl, !SER_ROWS[i][19]);
				u_arp_host_model.recv_byte(bl, r, ok);
			join
			check(r, SER_ROWS[i][7:0]);
			check({7'h0, ok}, 8'h01);
		end
		strobe(1'b0, 1'b1, ADDR_IRQ_STAT, 8'h00);
		check(r, 8'h0a);
		strobe(1'b0, 1'b1, ADDR_STATUS, 8'h00);
		check(r, 8'h1e);
		strobe(1'b0, 1'b1, ADDR_BAUD, 8'h00);
		check(r, 8'h06);
		strobe(1'b0, 1'b1, ADDR_LAST_REQ, 8'h00);
		check(r, 8'h0d);
		results();
	end
endmodule : testbench
